// file: logic/irq_bank_defs.vh
// register indices, field masks, reset values and codes of the interrupt request bank
`ifndef IRQ_BANK_DEFS_VH
`define IRQ_BANK_DEFS_VH

// register indices; the byte address is four times the index
`define IDX_FLAGS0 12'hfc0
`define IDX_ENH0 12'hfc1
`define IDX_ENL0 12'hfc2
`define IDX_FLAGS1 12'hfc3
`define IDX_ENH1 12'hfc4
`define IDX_ENL1 12'hfc5
`define IDX_FLAGS2 12'hfc6
`define IDX_ENH2 12'hfc7
`define IDX_ENL2 12'hfc8
`define IDX_CONTROL 12'hfcf
`define IDX_EVENT_STATUS 12'hfd0
`define IDX_EVENT_MASK 12'hfd1

// implemented bits of each bank; reserved bits hold zero
`define BANK0_MASK 8'h79
`define BANK1_MASK 8'hff
`define BANK2_MASK 8'h0f
`define REG_RESET 8'h00

// control register field
`define CTRL_GLOBAL_EN_BIT 7

// event status bits
`define EVT_HW_REQUEST 0
`define EVT_ACK 1
`define EVT_BYPASS 2
`define EVT_WIDTH 3

// arbitration
`define NUM_SOURCES 17
`define VEC_WIDTH 5
`define LVL_DISABLED 2'b00

// ahb codes
`define HTRANS_NONSEQ 1'b1
`define HRESP_OKAY 1'b0

`endif

// file: logic/request_latch.v
// one eight-bit bank of latched interrupt requests
`timescale 1ns/10ps
module request_latch #(
  parameter [7:0] VALID_MASK = 8'hff
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [7:0] hw_set,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire [7:0] ack_clr,
  output reg [7:0] flags
);

  reg [7:0] next_flags;

  // write replaces the bank, ack clears one bit, hardware pulses always win
  always @* begin
    if (wr_en) begin
      next_flags = wr_data;
    end else begin
      next_flags = flags & ~ack_clr;
    end
    next_flags = (next_flags | hw_set) & VALID_MASK;
  end

  // the source pulses once, so the bit must be held here
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags <= 8'h00;
    end else begin
      flags <= next_flags;
    end
  end

endmodule // request_latch

// file: logic/priority_select.v
// picks the winning request by level, then by fixed source order
`timescale 1ns/10ps
module priority_select #(
  parameter N = 17
) (
  input wire [N-1:0] pending,
  input wire [2*N-1:0] levels,
  output reg found,
  output reg [4:0] index,
  output reg [1:0] level
);

  integer i;
  reg [1:0] lv;

  // level field of source k
  function [1:0] level_of;
    input [2*N-1:0] all;
    input integer k;
    begin
      level_of = {all[2*k+1], all[2*k]};
    end
  endfunction

  // scan from last to first so the earlier source wins a tie
  always @* begin
    lv = 2'b00;
    found = 1'b0;
    index = 5'h00;
    level = 2'b00;
    for (i = N - 1; i >= 0; i = i - 1) begin
      lv = level_of(levels, i);
      if (pending[i] && (lv != 2'b00) && (lv >= level)) begin
        found = 1'b1;
        index = i[4:0];
        level = lv;
      end
    end
  end

endmodule // priority_select

// file: logic/interrupt_request_and_enable_bank.v
// interrupt request latching, priority enables and arbitration behind an ahb-lite slave
`timescale 1ns/10ps
`include "irq_bank_defs.vh"
module interrupt_request_and_enable_bank (
  input wire clk_sys,
  input wire rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire second_timer_request,
  input wire first_timer_request,
  input wire serial_receive_request,
  input wire serial_transmit_request,
  input wire converter_request,
  input wire pin7_or_voltage_request,
  input wire pin6_or_comparator_request,
  input wire [5:0] porta_pin_request,
  input wire [3:0] portc_pin_request,
  input wire watchdog_request,
  input wire primary_osc_fail,
  input wire watchdog_osc_fail,
  input wire core_ack,
  input wire return_from_interrupt,
  input wire trap_taken,
  output reg service_request,
  output reg [4:0] service_vector,
  output reg [1:0] service_level,
  output reg bypass_request,
  output reg irq
);

  // bus state
  reg data_wr;
  reg data_rd;
  reg [11:0] data_idx;

  // enable and control registers
  reg [7:0] enable_high_bank0;
  reg [7:0] enable_low_bank0;
  reg [7:0] enh1;
  reg [7:0] enl1;
  reg [7:0] enh2;
  reg [7:0] enl2;
  reg global_interrupt_enable;
  reg [`EVT_WIDTH-1:0] event_status;
  reg [`EVT_WIDTH-1:0] event_mask;

  wire [7:0] request_flags_0;
  wire [7:0] request_flags_1;
  wire [7:0] request_flags_2;
  wire [7:0] hw0;
  wire [7:0] hw1;
  wire [7:0] hw2;
  wire [7:0] clr0;
  wire [7:0] clr1;
  wire [7:0] clr2;
  wire [`NUM_SOURCES-1:0] ack_hot;
  wire [`NUM_SOURCES-1:0] pending;
  wire [2*`NUM_SOURCES-1:0] levels;
  wire win_found;
  wire [4:0] win_index;
  wire [1:0] win_level;
  wire addr_take;
  wire ack_taken;
  wire bypass_now;
  wire [7:0] wbyte;
  reg [7:0] rd_byte;
  reg [`EVT_WIDTH-1:0] next_event_status;

  // write strobe for one register index during the data phase
  function wr_hit;
    input wr;
    input [11:0] idx;
    input [11:0] target;
    begin
      wr_hit = wr && (idx == target);
    end
  endfunction

  // an address phase is taken only when the bus is ready and a nonseq/seq is shown
  assign addr_take = hsel && hready && (htrans[1] == `HTRANS_NONSEQ);
  assign wbyte = hwdata[7:0];

  // hardware pulses placed at their bank positions
  assign hw0 = {1'b0, second_timer_request, first_timer_request, serial_receive_request,
                serial_transmit_request, 2'b00, converter_request};
  assign hw1 = {pin7_or_voltage_request, pin6_or_comparator_request,
                porta_pin_request};
  assign hw2 = {4'h0, portc_pin_request};

  // acknowledge only counts while a request is actually presented
  assign ack_taken = core_ack && service_request;
  assign ack_hot = ack_taken ? (17'h00001 << service_vector) : 17'h00000;

  // order index back to bank bit: 0..4 bank0, 5..12 bank1 b7..b0, 13..16 bank2 b3..b0
  assign clr0 = {1'b0, ack_hot[0], ack_hot[1], ack_hot[2], ack_hot[3], 2'b00, ack_hot[4]};
  assign clr1 = {ack_hot[5], ack_hot[6], ack_hot[7], ack_hot[8],
                 ack_hot[9], ack_hot[10], ack_hot[11], ack_hot[12]};
  assign clr2 = {4'h0, ack_hot[13], ack_hot[14], ack_hot[15], ack_hot[16]};

  request_latch #(
    .VALID_MASK(`BANK0_MASK)
  ) u_bank0 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hw_set(hw0),
    .wr_en(wr_hit(data_wr, data_idx, `IDX_FLAGS0)),
    .wr_data(wbyte),
    .ack_clr(clr0),
    .flags(request_flags_0)
  );

  request_latch #(
    .VALID_MASK(`BANK1_MASK)
  ) u_bank1 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hw_set(hw1),
    .wr_en(wr_hit(data_wr, data_idx, `IDX_FLAGS1)),
    .wr_data(wbyte),
    .ack_clr(clr1),
    .flags(request_flags_1)
  );

  request_latch #(
    .VALID_MASK(`BANK2_MASK)
  ) u_bank2 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hw_set(hw2),
    .wr_en(wr_hit(data_wr, data_idx, `IDX_FLAGS2)),
    .wr_data(wbyte),
    .ack_clr(clr2),
    .flags(request_flags_2)
  );

  // sources flattened in vector order, first entry wins a tie of levels
  assign pending = {request_flags_2[0], request_flags_2[1], request_flags_2[2],
                    request_flags_2[3], request_flags_1[0], request_flags_1[1],
                    request_flags_1[2], request_flags_1[3], request_flags_1[4],
                    request_flags_1[5], request_flags_1[6], request_flags_1[7],
                    request_flags_0[0], request_flags_0[3], request_flags_0[4],
                    request_flags_0[5], request_flags_0[6]};
  assign levels = {enh2[0], enl2[0], enh2[1], enl2[1], enh2[2], enl2[2], enh2[3], enl2[3],
                   enh1[0], enl1[0], enh1[1], enl1[1], enh1[2], enl1[2], enh1[3], enl1[3],
                   enh1[4], enl1[4], enh1[5], enl1[5], enh1[6], enl1[6], enh1[7], enl1[7],
                   enable_high_bank0[0], enable_low_bank0[0],
                   enable_high_bank0[3], enable_low_bank0[3],
                   enable_high_bank0[4], enable_low_bank0[4],
                   enable_high_bank0[5], enable_low_bank0[5],
                   enable_high_bank0[6], enable_low_bank0[6]};

  priority_select #(
    .N(`NUM_SOURCES)
  ) u_select (
    .pending(pending),
    .levels(levels),
    .found(win_found),
    .index(win_index),
    .level(win_level)
  );

  // watchdog and oscillator traps never pass through the request banks
  assign bypass_now = watchdog_request || primary_osc_fail || watchdog_osc_fail;

  // ahb-lite slave: writes finish in one data cycle, reads take one wait state
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_wr <= 1'b0;
      data_rd <= 1'b0;
      data_idx <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      data_wr <= 1'b0;
      hresp <= `HRESP_OKAY;
      if (data_rd) begin
        data_rd <= 1'b0;
        hreadyout <= 1'b1;
      end else if (addr_take) begin
        data_idx <= haddr[13:2];
        data_wr <= hwrite;
        data_rd <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  // read mux; sampling late avoids returning data older than a preceding write
  always @* begin
    case (data_idx)
      `IDX_FLAGS0: rd_byte = request_flags_0;
      `IDX_ENH0: rd_byte = enable_high_bank0;
      `IDX_ENL0: rd_byte = enable_low_bank0;
      `IDX_FLAGS1: rd_byte = request_flags_1;
      `IDX_ENH1: rd_byte = enh1;
      `IDX_ENL1: rd_byte = enl1;
      `IDX_FLAGS2: rd_byte = request_flags_2;
      `IDX_ENH2: rd_byte = enh2;
      `IDX_ENL2: rd_byte = enl2;
      `IDX_CONTROL: rd_byte = {global_interrupt_enable, 7'h00};
      `IDX_EVENT_STATUS: rd_byte = {5'h00, event_status};
      `IDX_EVENT_MASK: rd_byte = {5'h00, event_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // read data lands at the end of the wait state; unmapped words read zero
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (data_rd) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // enable registers; reserved bank0 and bank2 bits are forced to zero
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enable_high_bank0 <= `REG_RESET;
      enable_low_bank0 <= `REG_RESET;
      enh1 <= `REG_RESET;
      enl1 <= `REG_RESET;
      enh2 <= `REG_RESET;
      enl2 <= `REG_RESET;
      event_mask <= 3'b000;
    end else begin
      if (wr_hit(data_wr, data_idx, `IDX_ENH0)) begin
        enable_high_bank0 <= wbyte & `BANK0_MASK;
      end
      if (wr_hit(data_wr, data_idx, `IDX_ENL0)) begin
        enable_low_bank0 <= wbyte & `BANK0_MASK;
      end
      if (wr_hit(data_wr, data_idx, `IDX_ENH1)) begin
        enh1 <= wbyte;
      end
      if (wr_hit(data_wr, data_idx, `IDX_ENL1)) begin
        enl1 <= wbyte;
      end
      if (wr_hit(data_wr, data_idx, `IDX_ENH2)) begin
        enh2 <= wbyte & `BANK2_MASK;
      end
      if (wr_hit(data_wr, data_idx, `IDX_ENL2)) begin
        enl2 <= wbyte & `BANK2_MASK;
      end
      if (wr_hit(data_wr, data_idx, `IDX_EVENT_MASK)) begin
        event_mask <= wbyte[`EVT_WIDTH-1:0];
      end
    end
  end

  // global enable: any clearing cause beats a same-cycle return or write of one
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      global_interrupt_enable <= 1'b0;
    end else if (ack_taken || trap_taken || primary_osc_fail || watchdog_osc_fail) begin
      global_interrupt_enable <= 1'b0;
    end else if (return_from_interrupt) begin
      global_interrupt_enable <= 1'b1;
    end else if (wr_hit(data_wr, data_idx, `IDX_CONTROL)) begin
      global_interrupt_enable <= wbyte[`CTRL_GLOBAL_EN_BIT];
    end
  end

  // sticky events; a read clears them but a new event in that cycle survives
  always @* begin
    next_event_status = event_status;
    if (data_rd && (data_idx == `IDX_EVENT_STATUS)) begin
      next_event_status = 3'b000;
    end
    next_event_status[`EVT_HW_REQUEST] = next_event_status[`EVT_HW_REQUEST] |
                                         (|{hw0, hw1, hw2});
    next_event_status[`EVT_ACK] = next_event_status[`EVT_ACK] | ack_taken;
    next_event_status[`EVT_BYPASS] = next_event_status[`EVT_BYPASS] | bypass_now;
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      event_status <= 3'b000;
      irq <= 1'b0;
    end else begin
      event_status <= next_event_status;
      irq <= |(next_event_status & event_mask);
    end
  end

  // service outputs; dropped in the ack cycle so one request is not served twice
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      service_request <= 1'b0;
      service_vector <= 5'h00;
      service_level <= `LVL_DISABLED;
      bypass_request <= 1'b0;
    end else begin
      bypass_request <= bypass_now;
      service_request <= global_interrupt_enable && win_found && !ack_taken;
      if (!service_request || ack_taken) begin
        service_vector <= win_index;
        service_level <= win_level;
      end
    end
  end

endmodule // interrupt_request_and_enable_bank

// file: sim/irq_bank_checker.sv
// bus, bypass and service link checks bound to the request bank top
`timescale 1ns/10ps
module irq_bank_checker (
  input wire clk_sys,
  input wire rst_b,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire watchdog_request,
  input wire primary_osc_fail,
  input wire watchdog_osc_fail,
  input wire core_ack,
  input wire trap_taken,
  input wire service_request,
  input wire [4:0] service_vector,
  input wire [1:0] service_level,
  input wire bypass_request,
  input wire irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // decoded bus take and bypass cause
  wire bus_take = hsel && hready && htrans[1];
  wire bp_in = watchdog_request || primary_osc_fail || watchdog_osc_fail;
  property p_rd_wait;
    bus_take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait is not one cycle");
  property p_wr_ready;
    bus_take && hwrite |=> hreadyout;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write was stalled");
  property p_okay;
    bus_take |=> !hresp [*2];
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_bp_set;
    bp_in |=> bypass_request;
  endproperty
  a_bp_set: assert property (p_bp_set) else $error("bypass not raised");
  property p_bp_clr;
    !bp_in |=> !bypass_request;
  endproperty
  a_bp_clr: assert property (p_bp_clr) else $error("bypass without cause");
  property p_ack_drop;
    service_request && core_ack |=> !service_request;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
  // the request may already be launched at the trap edge, so allow one cycle
  property p_trap_drop;
    trap_taken || primary_osc_fail || watchdog_osc_fail |-> ##2 !service_request;
  endproperty
  a_trap_drop: assert property (p_trap_drop) else $error("request kept after trap");
  property p_frozen;
    service_request && $past(service_request) |->
      $stable(service_vector) && $stable(service_level);
  endproperty
  a_frozen: assert property (p_frozen) else $error("winner moved while pending");
  property p_level;
    service_request |-> service_level != 2'b00;
  endproperty
  a_level: assert property (p_level) else $error("disabled source forwarded");
  c_ack: cover property (service_request && core_ack);
  c_irq: cover property ($rose(irq));
  c_bypass: cover property (bypass_request);
  c_rd: cover property (bus_take && !hwrite);
endmodule // irq_bank_checker

bind interrupt_request_and_enable_bank irq_bank_checker irq_bank_checker_inst (
  .clk_sys, .rst_b, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .watchdog_request, .primary_osc_fail, .watchdog_osc_fail, .core_ack, .trap_taken,
  .service_request, .service_vector, .service_level, .bypass_request, .irq
);

// file: sim/core_model.sv
// core stand-in: acknowledges service requests and returns after a short handler
`timescale 1ns/10ps
module core_model (
  input wire clk_sys,
  input wire rst_b,
  input wire service_request,
  input wire [4:0] service_vector,
  input wire [1:0] service_level,
  output reg core_ack,
  output reg return_from_interrupt
);
  reg [1:0] st;
  reg [2:0] cnt;
  reg slow;
  reg [4:0] log_vec [0:7];
  reg [1:0] log_lvl [0:7];
  reg [2:0] n;
  // acks alternate prompt and slow so held requests get exercised
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= 2'd0;
      cnt <= 3'd0;
      slow <= 1'b0;
      n <= 3'd0;
      core_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
      case (st)
        2'd0: if (service_request) begin
          cnt <= slow ? 3'd3 : 3'd0;
          st <= 2'd1;
        end
        2'd1: if (cnt != 3'd0) cnt <= cnt - 3'd1;
          else begin
            core_ack <= 1'b1;
            st <= 2'd2;
          end
        2'd2: begin
          log_vec[n] <= service_vector;
          log_lvl[n] <= service_level;
          n <= n + 3'd1;
          cnt <= 3'd4;
          slow <= !slow;
          st <= 2'd3;
        end
        default: if (cnt != 3'd0) cnt <= cnt - 3'd1;
          else begin
            return_from_interrupt <= 1'b1;
            st <= 2'd0;
          end
      endcase
    end
  end
endmodule // core_model

// file: sim/interrupt_request_and_enable_bank_tb_top.sv
// register-level bench for the interrupt request and enable bank
`timescale 1ns/10ps
`include "irq_bank_defs.vh"
module interrupt_request_and_enable_bank_tb_top;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg wdog = 1'b0;
  reg trap = 1'b0;
  reg posc = 1'b0;
  reg wosc = 1'b0;
  reg [1:0] htrans = 2'b00;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [16:0] src = 17'h0;
  reg [7:0] q;
  reg [11:0] a;
  wire hreadyout, hresp, service_request, bypass_request, irq, core_ack, rfi;
  wire [31:0] hrdata;
  wire [4:0] service_vector;
  wire [1:0] service_level;
  integer mismatches = 0;
  integer n_checks = 0;
  integer i, b;
  always #12.5 clk_sys = ~clk_sys;
  // src bit i is the source with order index i
  interrupt_request_and_enable_bank interrupt_request_and_enable_bank_inst (
    .clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .second_timer_request(src[0]), .first_timer_request(src[1]),
    .serial_receive_request(src[2]), .serial_transmit_request(src[3]),
    .converter_request(src[4]), .pin7_or_voltage_request(src[5]),
    .pin6_or_comparator_request(src[6]),
    .porta_pin_request({src[7], src[8], src[9], src[10], src[11], src[12]}),
    .portc_pin_request({src[13], src[14], src[15], src[16]}),
    .watchdog_request(wdog), .primary_osc_fail(posc), .watchdog_osc_fail(wosc),
    .core_ack, .return_from_interrupt(rfi), .trap_taken(trap), .service_request,
    .service_vector, .service_level, .bypass_request, .irq
  );
  core_model core_model_inst (
    .clk_sys, .rst_b, .service_request, .service_vector, .service_level,
    .core_ack, .return_from_interrupt(rfi)
  );
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one single transfer; p pulses sources during the data phase
  task bus(input w, input [11:0] idx, input [7:0] d, input [16:0] p);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {18'h0, idx, 2'b00};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      src <= p;
      @(posedge clk_sys);
      if (p != 17'h0) src <= 17'h0;
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      q = hrdata[7:0];
    end
  endtask
  task wr(input [11:0] idx, input [7:0] d);
    bus(1'b1, idx, d, 17'h0);
  endtask
  task rd(input [11:0] idx, input [7:0] e);
    begin
      bus(1'b0, idx, 8'h00, 17'h0);
      chk(q, e);
    end
  endtask
  task wrck(input [11:0] idx, input [7:0] d, input [7:0] e);
    begin
      wr(idx, d);
      rd(idx, e);
    end
  endtask
  // sources hold a request for exactly one clock
  task pulse(input [16:0] v);
    begin
      src <= v;
      @(posedge clk_sys);
      src <= 17'h0;
      @(posedge clk_sys);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #250000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(`IDX_FLAGS0, `REG_RESET);
    rd(`IDX_ENH0, `REG_RESET);
    rd(`IDX_ENL0, `REG_RESET);
    rd(`IDX_FLAGS1, `REG_RESET);
    rd(`IDX_FLAGS2, `REG_RESET);
    wrck(`IDX_FLAGS0, 8'hff, 8'h79);
    wrck(`IDX_ENH0, 8'hff, 8'h79);
    wrck(`IDX_ENL0, 8'hff, 8'h79);
    wrck(`IDX_FLAGS1, 8'hff, 8'hff);
    wrck(`IDX_FLAGS2, 8'hff, 8'h0f);
    wrck(12'h010, 8'hff, 8'h00);
    wrck(`IDX_FLAGS0, 8'h00, 8'h00);
    wrck(`IDX_ENH0, 8'h00, 8'h00);
    wrck(`IDX_ENL0, 8'h00, 8'h00);
    wrck(`IDX_FLAGS1, 8'h00, 8'h00);
    wrck(`IDX_FLAGS2, 8'h00, 8'h00);
    // remaining enables, control and mask, with nothing pending
    wrck(`IDX_ENH1, 8'hff, 8'hff);
    wrck(`IDX_ENL1, 8'hff, 8'hff);
    wrck(`IDX_ENH2, 8'hff, 8'h0f);
    wrck(`IDX_ENL2, 8'hff, 8'h0f);
    wrck(`IDX_CONTROL, 8'hff, 8'h80);
    wrck(`IDX_EVENT_MASK, 8'hff, 8'h07);
    wrck(`IDX_CONTROL, 8'h00, 8'h00);
    wrck(`IDX_EVENT_MASK, 8'h00, 8'h00);
    wrck(`IDX_ENH1, 8'h00, 8'h00);
    wrck(`IDX_ENL1, 8'h00, 8'h00);
    wrck(`IDX_ENH2, 8'h00, 8'h00);
    wrck(`IDX_ENL2, 8'h00, 8'h00);
    $display("test map and reset done");
    // every source alone, global enable off, so bits are only polled
    for (i = 0; i < 17; i = i + 1) begin
      a = (i < 5) ? `IDX_FLAGS0 : (i < 13) ? `IDX_FLAGS1 : `IDX_FLAGS2;
      b = (i == 4) ? 0 : (i < 5) ? 6 - i : (i < 13) ? 12 - i : 16 - i;
      pulse(17'h1 << i);
      rd(a, 8'h01 << b);
      chk(service_request, 1'b0);
      wrck(a, 8'h00, 8'h00);
    end
    $display("test source positions done");
    // levels 1..3 and off; converter and port a pin0 tie at level 3
    wr(`IDX_ENH0, 8'h41);
    wr(`IDX_ENL0, 8'h21);
    wr(`IDX_ENH1, 8'h01);
    wr(`IDX_ENL1, 8'h01);
    wr(`IDX_FLAGS0, 8'h79);
    wr(`IDX_FLAGS1, 8'h01);
    chk(service_request, 1'b0);
    wr(`IDX_CONTROL, 8'h80);
    for (i = 0; i < 400 && core_model_inst.n < 4; i = i + 1) @(posedge clk_sys);
    for (i = 0; i < 4; i = i + 1) begin
      chk(core_model_inst.log_vec[i], {5'd1, 5'd0, 5'd12, 5'd4} >> (5 * i) & 5'h1f);
      chk(core_model_inst.log_lvl[i], 8'b01_10_11_11 >> (2 * i) & 2'h3);
    end
    rd(`IDX_FLAGS0, 8'h18);
    rd(`IDX_FLAGS1, 8'h00);
    $display("test priority service done");
    // clearing write racing a pin pulse in its update cycle
    bus(1'b1, `IDX_FLAGS2, 8'h00, 17'h1 << 13);
    rd(`IDX_FLAGS2, 8'h08);
    wr(`IDX_FLAGS2, 8'h00);
    $display("test write race done");
    // port c pin3 at level 2 and pin0 at level 1, pulsed together
    wr(`IDX_ENH2, 8'h08);
    wr(`IDX_ENL2, 8'h01);
    pulse(17'h12000);
    for (i = 0; i < 400 && core_model_inst.n < 6; i = i + 1) @(posedge clk_sys);
    chk(core_model_inst.log_vec[4], 5'd13);
    chk(core_model_inst.log_lvl[4], 2'd2);
    chk(core_model_inst.log_vec[5], 5'd16);
    chk(core_model_inst.log_lvl[5], 2'd1);
    rd(`IDX_FLAGS2, 8'h00);
    wr(`IDX_ENH2, 8'h00);
    wr(`IDX_ENL2, 8'h00);
    $display("test port c service done");
    rd(`IDX_EVENT_STATUS, 8'h03);
    wr(`IDX_EVENT_MASK, 8'h00);
    wdog <= 1'b1;
    @(posedge clk_sys);
    wdog <= 1'b0;
    #1 chk(bypass_request, 1'b1);
    @(posedge clk_sys);
    rd(`IDX_FLAGS0, 8'h18);
    chk(irq, 1'b0);
    wr(`IDX_EVENT_MASK, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    rd(`IDX_EVENT_STATUS, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    $display("test event interrupt done");
    // trap and both oscillator failures drop the global enable
    rd(`IDX_CONTROL, 8'h80);
    trap <= 1'b1;
    @(posedge clk_sys);
    trap <= 1'b0;
    @(posedge clk_sys);
    rd(`IDX_CONTROL, 8'h00);
    wr(`IDX_CONTROL, 8'h80);
    posc <= 1'b1;
    @(posedge clk_sys);
    posc <= 1'b0;
    #1 chk(bypass_request, 1'b1);
    @(posedge clk_sys);
    rd(`IDX_CONTROL, 8'h00);
    wr(`IDX_CONTROL, 8'h80);
    wosc <= 1'b1;
    @(posedge clk_sys);
    wosc <= 1'b0;
    #1 chk(bypass_request, 1'b1);
    @(posedge clk_sys);
    rd(`IDX_CONTROL, 8'h00);
    rd(`IDX_FLAGS0, 8'h18);
    rd(`IDX_EVENT_STATUS, 8'h04);
    $display("test global enable done");
    wrap_up;
  end
endmodule // interrupt_request_and_enable_bank_tb_top
